// ### design/lce_line_ctrl.sv
// Three-channel line control bank: edge selects, build-out, signal loss control
//
// Notes on behaviour
// R01 - Select 0: sample tx rails on falling edge
// R02 - Select 1: sample tx rails on rising edge
// R03 - Each channel holds its own tx edge select
// R04 - Software sets build-out by cable length
// R05 - Build-out select ignored in E3 mode
// R06 - Bit 5 set turns digital loss detector off
// R07 - Bit 4 set turns analog loss detector off
// R08 - Detector disables act only at DS3/STS-1
// R09 - Rx select 0: data on rising clock edge
// R10 - Rx select 1: data on falling clock edge
// R11 - Rx control resets to zero, bits 7-6 zero
// R12 - Rx control at 0x05 and 0x0D per channel
// R13 - Mute forces rx rails low during loss
// R14 - Monitor mode accepts attenuated signal without loss
// R15 - Writes to unused bits ignored, read zero
`timescale 1ns/1ps
module lce_line_ctrl
    import lce_pkg::*;
#(
    parameter int NUM_CH = LCE_NUM_CH
)
(
    input wire logic clk,
    input wire logic rstn,
    // Host register port
    input wire logic [LCE_AW-1:0] host_addr,
    input wire logic host_wr_en,
    input wire logic host_rd_en,
    input wire logic [LCE_DW-1:0] host_wdata,
    output logic [LCE_DW-1:0] host_rdata,
    // Channel rate strap from channel control, 1 means E3
    input wire logic [NUM_CH-1:0] e3_mode,
    // Transmit side pins from terminal equipment
    input wire logic [NUM_CH-1:0] tx_line_clock,
    input wire logic [NUM_CH-1:0] tx_pos_rail_in,
    input wire logic [NUM_CH-1:0] tx_neg_rail_in,
    // Sampled transmit rails towards the encoder
    output logic [NUM_CH-1:0] tx_pos_sampled,
    output logic [NUM_CH-1:0] tx_neg_sampled,
    output logic [NUM_CH-1:0] tx_sample_strobe,
    output logic [NUM_CH-1:0] tx_build_out_active,
    // Receive side from clock and data recovery
    input wire logic [NUM_CH-1:0] rx_rec_clock,
    input wire logic [NUM_CH-1:0] rx_rec_pos,
    input wire logic [NUM_CH-1:0] rx_rec_neg,
    // Raw detector indications
    input wire logic [NUM_CH-1:0] digital_signal_loss,
    input wire logic [NUM_CH-1:0] analog_signal_loss,
    // Receive outputs to terminal equipment
    output logic [NUM_CH-1:0] rx_clock_out,
    output logic [NUM_CH-1:0] rx_pos_rail_out,
    output logic [NUM_CH-1:0] rx_neg_rail_out,
    // Detector and front-end controls, and loss status
    output logic [NUM_CH-1:0] digital_detector_enable,
    output logic [NUM_CH-1:0] analog_detector_enable,
    output logic [NUM_CH-1:0] rx_monitor_mode,
    output logic [NUM_CH-1:0] rx_equalizer_enable,
    output logic [NUM_CH-1:0] signal_loss_declared
);
    // Per-channel control registers
    logic [LCE_DW-1:0] rxc_q [NUM_CH];
    logic [LCE_DW-1:0] txc_q [NUM_CH];
    // Synchronised strap and detector levels
    logic [NUM_CH-1:0] e3_s1_q, e3_s2_q;
    logic [NUM_CH-1:0] digital_signal_loss_s1_q, digital_signal_loss_s2_q;
    logic [NUM_CH-1:0] analog_signal_loss_s1_q, analog_signal_loss_s2_q;
    // Combinational loss and mute terms
    logic [NUM_CH-1:0] los_now;
    logic [NUM_CH-1:0] mute_now;
    // Read data next value
    logic [LCE_DW-1:0] rdata_d;

    // Strap and detector synchronisers; stage 1 feeds only stage 2
    always_ff @(posedge clk) begin
        if (!rstn) begin
            e3_s1_q <= '0;
            e3_s2_q <= '0;
            digital_signal_loss_s1_q <= '0;
            digital_signal_loss_s2_q <= '0;
            analog_signal_loss_s1_q <= '0;
            analog_signal_loss_s2_q <= '0;
        end else begin
            e3_s1_q <= e3_mode;
            e3_s2_q <= e3_s1_q;
            digital_signal_loss_s1_q <= digital_signal_loss;
            digital_signal_loss_s2_q <= digital_signal_loss_s1_q;
            analog_signal_loss_s1_q <= analog_signal_loss;
            analog_signal_loss_s2_q <= analog_signal_loss_s1_q;
        end
    end

    // One register pair, sampler and output stage per channel
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        // Addresses step by the channel stride
        localparam logic [7:0] RXA = 8'(LCE_RXC_OFS_CH0 + LCE_CH_STRIDE * i);
        localparam logic [7:0] TXA = 8'(LCE_TXC_OFS_CH0 + LCE_CH_STRIDE * i);

        // Receive control; unused upper bits never store
        always_ff @(posedge clk) begin
            if (!rstn) begin
                rxc_q[i] <= LCE_RXC_RST; // R11
            end else if (host_wr_en && host_addr == RXA) begin
                rxc_q[i] <= host_wdata & LCE_RXC_WMASK; // R12 R15
            end
        end

        // Transmit control, one copy per channel so edges stay independent
        always_ff @(posedge clk) begin
            if (!rstn) begin
                txc_q[i] <= LCE_TXC_RST;
            end else if (host_wr_en && host_addr == TXA) begin
                txc_q[i] <= host_wdata & LCE_TXC_WMASK; // R03
            end
        end

        // Disables only bite at DS3/STS-1; E3 keeps both detectors running
        assign digital_detector_enable[i] =
            !(rxc_q[i][LCE_RXC_DIGITAL_SIGNAL_LOSS_DIS_BIT] && !e3_s2_q[i]); // R06 R08
        assign analog_detector_enable[i] =
            !(rxc_q[i][LCE_RXC_ANALOG_SIGNAL_LOSS_DIS_BIT] && !e3_s2_q[i]); // R07 R08
        // Monitor mode tolerates a low analog level, so that cause is dropped
        assign los_now[i] = (digital_detector_enable[i] && digital_signal_loss_s2_q[i])
            || (analog_detector_enable[i] && analog_signal_loss_s2_q[i]
            && !rxc_q[i][LCE_RXC_MON_BIT]); // R14
        assign mute_now[i] = los_now[i] && rxc_q[i][LCE_RXC_MUTE_BIT]; // R13
        assign rx_monitor_mode[i] = rxc_q[i][LCE_RXC_MON_BIT]; // R14
        assign rx_equalizer_enable[i] = rxc_q[i][LCE_RXC_EQ_BIT];
        // Build-out has no meaning at the E3 rate
        assign tx_build_out_active[i] =
            txc_q[i][LCE_TXC_LBO_BIT] && !e3_s2_q[i]; // R05

        // Transmit rail capture
        lce_tx_sampler u_tx (
            .clk(clk),
            .rstn(rstn),
            .tx_line_clock(tx_line_clock[i]),
            .tx_pos_rail_in(tx_pos_rail_in[i]),
            .tx_neg_rail_in(tx_neg_rail_in[i]),
            .edge_sel(txc_q[i][LCE_TXC_EDGE_BIT]), // R01 R02 R03
            .pos_q(tx_pos_sampled[i]),
            .neg_q(tx_neg_sampled[i]),
            .strobe_q(tx_sample_strobe[i])
        );

        // Recovered data output
        lce_rx_output u_rx (
            .clk(clk),
            .rstn(rstn),
            .rec_clk_in(rx_rec_clock[i]),
            .rec_pos_in(rx_rec_pos[i]),
            .rec_neg_in(rx_rec_neg[i]),
            .edge_sel(rxc_q[i][LCE_RXC_EDGE_BIT]), // R09 R10
            .mute(mute_now[i]), // R13
            .rx_clk_out(rx_clock_out[i]),
            .pos_out(rx_pos_rail_out[i]),
            .neg_out(rx_neg_rail_out[i])
        );
    end

    // Loss status is registered so it never glitches on the pin
    always_ff @(posedge clk) begin
        if (!rstn) begin
            signal_loss_declared <= '0;
        end else begin
            signal_loss_declared <= los_now;
        end
    end

    // Read decode; unmapped addresses answer zero
    always_comb begin
        rdata_d = LCE_RD_UNMAPPED;
        for (int c = 0; c < NUM_CH; c++) begin
            if (host_addr == 8'(LCE_RXC_OFS_CH0 + LCE_CH_STRIDE * c)) begin
                rdata_d = rxc_q[c]; // R15
            end
            if (host_addr == 8'(LCE_TXC_OFS_CH0 + LCE_CH_STRIDE * c)) begin
                rdata_d = txc_q[c];
            end
        end
    end

    // Read data register, held between reads
    always_ff @(posedge clk) begin
        if (!rstn) begin
            host_rdata <= '0;
        end else if (host_rd_en) begin
            host_rdata <= rdata_d;
        end
    end

    // Channel 0 receive control takes the masked write one cycle later
    a_rxc0_write: assert property (@(posedge clk) disable iff (!rstn) // R12
        (host_wr_en && host_addr == LCE_RXC_OFS_CH0)
        |=> rxc_q[0] == ($past(host_wdata) & LCE_RXC_WMASK))
        else $error("rx control ch0 write lost");
    // Channel 1 sits at its own offset
    a_rxc1_write: assert property (@(posedge clk) disable iff (!rstn) // R12
        (host_wr_en && host_addr == LCE_RXC_OFS_CH1)
        |=> rxc_q[1] == ($past(host_wdata) & LCE_RXC_WMASK))
        else $error("rx control ch1 write lost");
    // Upper bits read back as zero after a channel 0 rx control read
    a_rxc_upper_zero: assert property (@(posedge clk) disable iff (!rstn) // R11 R15
        (host_rd_en && host_addr == LCE_RXC_OFS_CH0) |=> host_rdata[7:6] == 2'h0)
        else $error("unused rx bits not zero");
    // Reset leaves both detectors enabled
    a_rst_detect_on: assert property (@(posedge clk) // R11
        !rstn |=> (digital_detector_enable[0] && analog_detector_enable[0]))
        else $error("detectors off after reset");
    // Digital disable at DS3/STS-1 removes that loss cause
    a_digital_signal_loss_gate: assert property (@(posedge clk) disable iff (!rstn) // R06 R08
        (rxc_q[0][LCE_RXC_DIGITAL_SIGNAL_LOSS_DIS_BIT] && !e3_s2_q[0] && !analog_signal_loss_s2_q[0])
        |-> !los_now[0])
        else $error("digital loss not gated");
    // Analog disable at DS3/STS-1 removes that loss cause
    a_analog_signal_loss_gate: assert property (@(posedge clk) disable iff (!rstn) // R07 R08
        (rxc_q[0][LCE_RXC_ANALOG_SIGNAL_LOSS_DIS_BIT] && !e3_s2_q[0] && !digital_signal_loss_s2_q[0])
        |-> !los_now[0])
        else $error("analog loss not gated");
    // E3 keeps both detectors running whatever the bits say
    a_e3_detect_on: assert property (@(posedge clk) disable iff (!rstn) // R08
        e3_s2_q[0] |-> (digital_detector_enable[0] && analog_detector_enable[0]))
        else $error("detector disabled at E3");
    // Monitor mode never declares loss from the analog detector
    a_monitor_no_los: assert property (@(posedge clk) disable iff (!rstn) // R14
        (rxc_q[0][LCE_RXC_MON_BIT] && !digital_signal_loss_s2_q[0]) |=> !signal_loss_declared[0])
        else $error("loss declared in monitor");
    // Muted rails stay low through the loss
    a_mute_low: assert property (@(posedge clk) disable iff (!rstn) // R13
        mute_now[0] [*2] |-> (!rx_pos_rail_out[0] && !rx_neg_rail_out[0]))
        else $error("rails not muted");
    // Build-out never active in E3
    a_lbo_e3_off: assert property (@(posedge clk) disable iff (!rstn) // R05
        e3_s2_q[1] |-> !tx_build_out_active[1])
        else $error("build-out active at E3");

    // Host port checks on both control registers, read data and reset

    // Channel 0 transmit control takes the masked write
    a_txc0_write: assert property (@(posedge clk) disable iff (!rstn) // R03
        (host_wr_en && host_addr == LCE_TXC_OFS_CH0)
        |=> txc_q[0] == ($past(host_wdata) & LCE_TXC_WMASK))
        else $error("tx control ch0 write lost");

    // A channel 0 edge write leaves channel 1 alone
    a_txc_indep: assert property (@(posedge clk) disable iff (!rstn) // R03
        (host_wr_en && host_addr == LCE_TXC_OFS_CH0)
        |=> $stable(txc_q[1]))
        else $error("tx control leaked");

    // A channel 0 rx write leaves channel 1 alone
    a_rxc_indep: assert property (@(posedge clk) disable iff (!rstn) // R12
        (host_wr_en && host_addr == LCE_RXC_OFS_CH0)
        |=> $stable(rxc_q[1]))
        else $error("rx control leaked");

    // Read data only moves on a read
    a_rdata_hold: assert property (@(posedge clk) disable iff (!rstn)
        !host_rd_en |=> $stable(host_rdata))
        else $error("read data moved");

    // Reset clears read data and channel 1 control
    a_rst_clear: assert property (@(posedge clk) // R11
        !rstn |=> (host_rdata == '0) && (rxc_q[1] == LCE_RXC_RST))
        else $error("state not cleared by reset");

    // Detector and line checks on channel 1 and 0

    // E3 on channel 1 keeps its detectors running too
    a_e3_detect_ch1: assert property (@(posedge clk) disable iff (!rstn) // R08
        e3_s2_q[1] |-> (digital_detector_enable[1] && analog_detector_enable[1]))
        else $error("ch1 detector disabled at E3");

    // Outside E3 the build-out bit passes straight through
    a_lbo_ds3: assert property (@(posedge clk) disable iff (!rstn) // R05
        !e3_s2_q[1] |-> tx_build_out_active[1] == txc_q[1][LCE_TXC_LBO_BIT])
        else $error("build-out lost outside E3");

    // Mute bit clear never mutes
    a_no_mute_off: assert property (@(posedge clk) disable iff (!rstn) // R13
        !rxc_q[0][LCE_RXC_MUTE_BIT] |-> !mute_now[0])
        else $error("muted with mute off");

    // A running digital detector that sees loss declares it
    a_digital_signal_loss_on: assert property (@(posedge clk) disable iff (!rstn) // R06
        (digital_detector_enable[0] && digital_signal_loss_s2_q[0]) |=> signal_loss_declared[0])
        else $error("digital loss not declared");

    // E3 masking a set disable bit seen
    c_e3_masked: cover property (@(posedge clk) disable iff (!rstn)
        e3_s2_q[0] && rxc_q[0][LCE_RXC_DIGITAL_SIGNAL_LOSS_DIS_BIT]);
    // Monitor mode riding through analog loss seen
    c_monitor_loss: cover property (@(posedge clk) disable iff (!rstn)
        rxc_q[2][LCE_RXC_MON_BIT] && analog_signal_loss_s2_q[2]);

    // Rising-edge transmit capture seen
    c_tx_rise: cover property (@(posedge clk) disable iff (!rstn)
        txc_q[0][LCE_TXC_EDGE_BIT] && tx_sample_strobe[0]);
    // Muting during loss seen
    c_rx_mute: cover property (@(posedge clk) disable iff (!rstn)
        mute_now[1] ##1 mute_now[1]);
    // Channels with different edges at once
    c_mixed_edges: cover property (@(posedge clk) disable iff (!rstn)
        txc_q[0][LCE_TXC_EDGE_BIT] != txc_q[2][LCE_TXC_EDGE_BIT]);
endmodule : lce_line_ctrl

// ### pkg/lce_pkg.sv
// Shared constants for the line channel edge and signal-loss control bank
package lce_pkg;
    // Channel count and host port widths
    localparam int LCE_NUM_CH = 3;
    localparam int LCE_AW = 8;
    localparam int LCE_DW = 8;
    // Receive control offset of channel 0 and per-channel stride
    localparam logic [7:0] LCE_RXC_OFS_CH0 = 8'h05;
    localparam logic [7:0] LCE_RXC_OFS_CH1 = 8'h0D;
    localparam logic [7:0] LCE_CH_STRIDE = 8'h08;
    // Transmit control offset of channel 0
    localparam logic [7:0] LCE_TXC_OFS_CH0 = 8'h04;
    // Receive control field positions
    localparam int LCE_RXC_EQ_BIT = 0;
    localparam int LCE_RXC_MON_BIT = 1;
    localparam int LCE_RXC_MUTE_BIT = 2;
    localparam int LCE_RXC_EDGE_BIT = 3;
    localparam int LCE_RXC_ANALOG_SIGNAL_LOSS_DIS_BIT = 4;
    localparam int LCE_RXC_DIGITAL_SIGNAL_LOSS_DIS_BIT = 5;
    // Transmit control field positions
    localparam int LCE_TXC_LBO_BIT = 0;
    localparam int LCE_TXC_EDGE_BIT = 1;
    // Writable masks; bits outside read back as zero
    localparam logic [7:0] LCE_RXC_WMASK = 8'h3F;
    localparam logic [7:0] LCE_TXC_WMASK = 8'h03;
    // Reset values
    localparam logic [7:0] LCE_RXC_RST = 8'h00;
    localparam logic [7:0] LCE_TXC_RST = 8'h00;
    localparam logic [7:0] LCE_RD_UNMAPPED = 8'h00;
endpackage : lce_pkg

// ### design/lce_tx_sampler.sv
// Transmit rail sampler: captures rail data on the selected line clock edge
`timescale 1ns/1ps
module lce_tx_sampler
    import lce_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic tx_line_clock,
    input wire logic tx_pos_rail_in,
    input wire logic tx_neg_rail_in,
    input wire logic edge_sel,
    output logic pos_q,
    output logic neg_q,
    output logic strobe_q
);
    // Synchroniser stages; stage 1 feeds only stage 2
    logic clk_s1_q, clk_s2_q, clk_s3_q;
    logic pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q;
    logic rise, fall, take;

    // Pin synchronisers, data and clock share the same latency
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {clk_s1_q, clk_s2_q, clk_s3_q} <= 3'h0;
            {pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q} <= 4'h0;
        end else begin
            clk_s1_q <= tx_line_clock;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            pos_s1_q <= tx_pos_rail_in;
            pos_s2_q <= pos_s1_q;
            neg_s1_q <= tx_neg_rail_in;
            neg_s2_q <= neg_s1_q;
        end
    end

    // Edge finding on the settled copy only
    assign rise = clk_s2_q & ~clk_s3_q;
    assign fall = ~clk_s2_q & clk_s3_q;
    // Select 0 takes the falling edge, 1 the rising edge
    assign take = edge_sel ? rise : fall; // R01 R02

    // Capture registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {pos_q, neg_q, strobe_q} <= 3'h0;
        end else begin
            strobe_q <= take;
            if (take) begin
                pos_q <= pos_s2_q; // R01 R02
                neg_q <= neg_s2_q;
            end
        end
    end

    // Capture only on the edge that the select names
    a_tx_edge_pick: assert property (@(posedge clk) disable iff (!rstn) // R01 R02
        strobe_q |-> $past(edge_sel) ? $past(rise) : $past(fall))
        else $error("tx capture on wrong edge");
    // Captured data equals the settled rail value at the edge
    a_tx_data_taken: assert property (@(posedge clk) disable iff (!rstn) // R01
        strobe_q |-> (pos_q == $past(pos_s2_q)) && (neg_q == $past(neg_s2_q)))
        else $error("tx capture data mismatch");
endmodule : lce_tx_sampler

// ### design/lce_rx_output.sv
// Receive output stage: drives recovered clock and rails on the selected edge
`timescale 1ns/1ps
module lce_rx_output
    import lce_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic rec_clk_in,
    input wire logic rec_pos_in,
    input wire logic rec_neg_in,
    input wire logic edge_sel,
    input wire logic mute,
    output logic rx_clk_out,
    output logic pos_out,
    output logic neg_out
);
    // Synchroniser stages; stage 1 feeds only stage 2
    logic clk_s1_q, clk_s2_q;
    logic pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q;
    logic rise, fall, upd;

    // Pin synchronisers and the outgoing clock copy
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {clk_s1_q, clk_s2_q, rx_clk_out} <= 3'h0;
            {pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q} <= 4'h0;
        end else begin
            clk_s1_q <= rec_clk_in;
            clk_s2_q <= clk_s1_q;
            rx_clk_out <= clk_s2_q;
            pos_s1_q <= rec_pos_in;
            pos_s2_q <= pos_s1_q;
            neg_s1_q <= rec_neg_in;
            neg_s2_q <= neg_s1_q;
        end
    end

    // Output clock edge that happens at this clk edge
    assign rise = clk_s2_q & ~rx_clk_out;
    assign fall = ~clk_s2_q & rx_clk_out;
    assign upd = edge_sel ? fall : rise; // R09 R10

    // Data changes together with the chosen output clock edge; mute wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            {pos_out, neg_out} <= 2'h0;
        end else if (mute) begin
            {pos_out, neg_out} <= 2'h0; // R13
        end else if (upd) begin
            pos_out <= pos_s2_q; // R09 R10
            neg_out <= neg_s2_q;
        end
    end

    // Unmuted data only moves on the selected clock edge
    a_rx_edge_pick: assert property (@(posedge clk) disable iff (!rstn) // R09 R10
        (!$past(mute) && (pos_out != $past(pos_out)))
        |-> ($past(edge_sel) ? $fell(rx_clk_out) : $rose(rx_clk_out)))
        else $error("rx data moved off edge");
endmodule : lce_rx_output

// ### dv/lce_framer_model.sv
// Terminal equipment model: drives transmit line clock and rail data
`timescale 1ns/1ps
module lce_framer_model #(
    parameter logic [31:0] SEED = 32'hBFC6A0F5,
    parameter int PHASE_NS = 7
)
(
    input wire logic run,
    input wire logic edge_sel,
    output logic line_clk,
    output logic pos,
    output logic neg,
    output logic exp_pos,
    output logic exp_neg
);
    int seed = SEED; // Fixed seed keeps runs repeatable
    // Clock stands still between frames; data moves only on the edge not sampled,
    // so it is stable for half a link period either side of the capture edge
    initial begin
        line_clk = 1'b0;
        {pos, neg, exp_pos, exp_neg} = 4'h0;
        #(PHASE_NS);
        forever begin
            if (!run) begin
                #40;
            end else begin
                line_clk = ~edge_sel; // Launch edge
                {pos, neg} = 2'($random(seed));
                #160;
                line_clk = edge_sel; // Capture edge
                {exp_pos, exp_neg} = {pos, neg};
                #160;
            end
        end
    end
endmodule : lce_framer_model

// ### dv/tb.sv
// Self-checking bench for the line control bank
`timescale 1ns/1ps
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
    import lce_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, d, ctl;
    logic host_wr_en = 1'b0, host_rd_en = 1'b0;
    logic [2:0] e3_mode = 3'h0, digital_signal_loss = 3'h0, analog_signal_loss = 3'h0;
    logic [2:0] rx_rec_clock = 3'h0, rx_rec_pos = 3'h0, rx_rec_neg = 3'h0;
    wire [2:0] tx_line_clock, tx_pos_rail_in, tx_neg_rail_in, exp_pos, exp_neg;
    logic [2:0] tx_pos_sampled, tx_neg_sampled, tx_sample_strobe, tx_build_out_active;
    logic [2:0] rx_clock_out, rx_pos_rail_out, rx_neg_rail_out, signal_loss_declared;
    logic [2:0] digital_detector_enable, analog_detector_enable;
    logic [2:0] rx_monitor_mode, rx_equalizer_enable;
    logic [2:0] tsel = 3'h0, rsel = 3'h0, pclk = 3'h0, lbo;
    logic [1:0] pdat [3];
    logic [1:0] rx_div = 2'h0;
    logic run = 1'b0, tx_chk = 1'b0, rx_chk = 1'b0, all_ones = 1'b0, den, aen, los;
    int n_strobe [3];
    int seed = 32'hBFC6A0F5; // Fixed seed for repeatable stimulus
    int n_fail = 0;
    int total_checks = 0;
    int c;

    // 25 MHz system clock
    always #20 clk = ~clk;

    lce_line_ctrl DUT (.clk(clk), .rstn(rstn), .host_addr(host_addr),
        .host_wr_en(host_wr_en), .host_rd_en(host_rd_en), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .e3_mode(e3_mode), .tx_line_clock(tx_line_clock),
        .tx_pos_rail_in(tx_pos_rail_in), .tx_neg_rail_in(tx_neg_rail_in),
        .tx_pos_sampled(tx_pos_sampled), .tx_neg_sampled(tx_neg_sampled),
        .tx_sample_strobe(tx_sample_strobe), .tx_build_out_active(tx_build_out_active),
        .rx_rec_clock(rx_rec_clock), .rx_rec_pos(rx_rec_pos), .rx_rec_neg(rx_rec_neg),
        .digital_signal_loss(digital_signal_loss), .analog_signal_loss(analog_signal_loss),
        .rx_clock_out(rx_clock_out), .rx_pos_rail_out(rx_pos_rail_out),
        .rx_neg_rail_out(rx_neg_rail_out), .digital_detector_enable(digital_detector_enable),
        .analog_detector_enable(analog_detector_enable), .rx_monitor_mode(rx_monitor_mode),
        .rx_equalizer_enable(rx_equalizer_enable), .signal_loss_declared(signal_loss_declared));

    // One framer model per channel, each with its own phase
    for (genvar g = 0; g < 3; g++) begin : g_fr
        lce_framer_model #(.SEED(32'hBFC6A0F5 + g), .PHASE_NS(7 + 5 * g)) u_fr (
            .run(run), .edge_sel(tsel[g]), .line_clk(tx_line_clock[g]),
            .pos(tx_pos_rail_in[g]), .neg(tx_neg_rail_in[g]),
            .exp_pos(exp_pos[g]), .exp_neg(exp_neg[g]));
    end

    // Recovered clock at 320 ns with fresh data at every clock edge
    always @(negedge clk) begin
        rx_div <= rx_div + 2'd1;
        if (rx_div == 2'd3) begin
            rx_rec_clock <= ~rx_rec_clock;
            {rx_rec_pos, rx_rec_neg} <= all_ones ? 6'h3F : 6'($random(seed));
        end
    end

    // Watch captured rails and the edge on which receive rails move
    always @(negedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (tx_chk && tx_sample_strobe[i] === 1'b1) begin
                n_strobe[i]++;
                `CHECK({tx_pos_sampled[i], tx_neg_sampled[i]}, {exp_pos[i], exp_neg[i]})
            end
            if (rx_chk && {rx_pos_rail_out[i], rx_neg_rail_out[i]} !== pdat[i]) begin
                `CHECK({pclk[i], rx_clock_out[i]}, rsel[i] ? 2'b10 : 2'b01)
            end
            pclk[i] = rx_clock_out[i];
            pdat[i] = {rx_pos_rail_out[i], rx_neg_rail_out[i]};
        end
    end

    function automatic logic [7:0] rx_ofs(input int ch);
        return LCE_RXC_OFS_CH0 + 8'(ch) * LCE_CH_STRIDE;
    endfunction : rx_ofs

    function automatic logic [7:0] tx_ofs(input int ch);
        return LCE_TXC_OFS_CH0 + 8'(ch) * LCE_CH_STRIDE;
    endfunction : tx_ofs

    // One-cycle write strobe, launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        host_addr = a;
        host_wdata = v;
        host_wr_en = 1'b1;
        @(negedge clk);
        host_wr_en = 1'b0;
    endtask : wr

    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        host_addr = a;
        host_rd_en = 1'b1;
        @(negedge clk);
        host_rd_en = 1'b0;
        v = host_rdata;
    endtask : rd

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        $display("timeout");
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        // Reset values, read-only bits, layout of both documented offsets
        for (int i = 0; i < 3; i++) begin
            rd(rx_ofs(i), d);
            `CHECK(d, 8'h00)
            wr(rx_ofs(i), 8'hFF);
            rd(rx_ofs(i), d);
            `CHECK(d, 8'h3F)
        end
        wr(8'h05, 8'h2A);
        wr(8'h0D, 8'h15);
        rd(8'h05, d);
        `CHECK(d, 8'h2A)
        rd(8'h0D, d);
        `CHECK(d, 8'h15)
        wr(8'h3F, 8'hFF);
        rd(8'h3F, d);
        `CHECK(d, 8'h00)
        $display("test regs done");
        // Transmit capture edge, mixed across channels then swapped
        for (int p = 0; p < 2; p++) begin
            tsel = p ? 3'b010 : 3'b101;
            for (int i = 0; i < 3; i++) wr(tx_ofs(i), {6'h00, tsel[i], 1'b0});
            n_strobe = '{0, 0, 0};
            tx_chk = 1'b1;
            run = 1'b1;
            repeat (320) @(negedge clk);
            run = 1'b0;
            repeat (20) @(negedge clk);
            tx_chk = 1'b0;
            for (int i = 0; i < 3; i++) `CHECK(n_strobe[i] >= 38, 1'b1)
        end
        $display("test tx_edge done");
        // Build-out select, which software picks by cable length, masked in E3
        for (int k = 0; k < 8; k++) begin
            lbo = 3'($random(seed));
            for (int i = 0; i < 3; i++) wr(tx_ofs(i), {6'h00, tsel[i], lbo[i]});
            e3_mode = 3'($random(seed));
            repeat (6) @(negedge clk);
            `CHECK(tx_build_out_active, lbo & ~e3_mode)
        end
        $display("test build_out done");
        // Detector disables, monitor mode, mute on loss
        all_ones = 1'b1;
        for (int k = 0; k < 32; k++) begin
            c = {$random(seed)} % 3;
            ctl = 8'($random(seed)) & 8'h3F;
            wr(rx_ofs(c), ctl);
            {e3_mode, digital_signal_loss, analog_signal_loss} = 9'($random(seed));
            repeat (10) @(negedge clk);
            den = ~ctl[5] | e3_mode[c];
            aen = ~ctl[4] | e3_mode[c];
            los = (digital_signal_loss[c] & den) | (analog_signal_loss[c] & aen & ~ctl[1]);
            `CHECK(digital_detector_enable[c], den)
            `CHECK(analog_detector_enable[c], aen)
            `CHECK(signal_loss_declared[c], los)
            `CHECK({rx_monitor_mode[c], rx_equalizer_enable[c]}, ctl[1:0])
            if (ctl[2] && los) `CHECK({rx_pos_rail_out[c], rx_neg_rail_out[c]}, 2'b00)
            if (!ctl[2] || !los) `CHECK({rx_pos_rail_out[c], rx_neg_rail_out[c]}, 2'b11)
        end
        all_ones = 1'b0;
        {digital_signal_loss, analog_signal_loss} = 6'h00;
        $display("test signal_loss done");
        // Receive output edge, mixed across channels then swapped
        for (int p = 0; p < 2; p++) begin
            rsel = p ? 3'b010 : 3'b101;
            for (int i = 0; i < 3; i++) wr(rx_ofs(i), {4'h0, rsel[i], 3'h0});
            repeat (8) @(negedge clk);
            rx_chk = 1'b1;
            repeat (200) @(negedge clk);
            rx_chk = 1'b0;
        end
        $display("test rx_edge done");
        finish_test();
    end
endmodule : tb
